// >>> verilog/dcc_map.svh
// offsets, field positions, reset values and timing figures of the comparator block
`ifndef DCC_MAP_SVH
`define DCC_MAP_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define DCC_ADDR_W      6
`define DCC_OFS_CTL0    6'h00
`define DCC_OFS_CTL1    6'h04
`define DCC_OFS_CFG     6'h08
`define DCC_OFS_ISTAT   6'h0c
`define DCC_OFS_IMASK   6'h10
`define DCC_OFS_SETTLE  6'h14

// ----------------------------------------
// control register fields
// ----------------------------------------
`define DCC_BIT_EN      7
`define DCC_BIT_OUT     6
`define DCC_BIT_RISE    5
`define DCC_BIT_FALL    4
`define DCC_HYP_HI      3
`define DCC_HYP_LO      2
`define DCC_HYN_HI      1
`define DCC_HYN_LO      0
`define DCC_HYST_OFF    2'h0

// ----------------------------------------
// configuration, interrupt and settle fields
// ----------------------------------------
`define DCC_CFG_W       5
`define DCC_CFG_RST0    0
`define DCC_CFG_ROUTE0  1
`define DCC_CFG_ROUTE1  2
`define DCC_CFG_PP0     3
`define DCC_CFG_PP1     4
`define DCC_IRQ_W       4
`define DCC_IRQ_RISE0   0
`define DCC_IRQ_FALL0   1
`define DCC_IRQ_RISE1   2
`define DCC_IRQ_FALL1   3
`define DCC_SET_CMP0    0
`define DCC_SET_CMP1    1

// ----------------------------------------
// reset values
// ----------------------------------------
`define DCC_RST_CFG     5'h00
`define DCC_RST_IRQ     4'h0
`define DCC_RST_WORD    32'h0000_0000

// ----------------------------------------
// timing
// ----------------------------------------
`define DCC_SETTLE_MS   20
`define DCC_CLK_HZ      50000000
`define DCC_MS_PER_S    1000

`endif

// >>> verilog/dcc_pkg.sv
// types shared by the comparator control block
package dcc_pkg;

    // analog-facing control of one comparator
    typedef struct packed {
        logic       en;
        logic [1:0] hystPos;
        logic [1:0] hystNeg;
    } dcc_ctrl_t;

    // one port pin: level driven and output enable
    typedef struct packed {
        logic out;
        logic oe;
    } dcc_pin_t;

endpackage

// >>> verilog/dcc_channel.sv
// one comparator channel: synchroniser, settle timer, edge detect, sticky flags
`timescale 1ns/1ps
module dcc_channel #(
    parameter int SETTLE_CYCLES = 1000000,
    parameter int CNT_W         = $clog2(SETTLE_CYCLES + 1)
) (
    // clock and reset
    input  wire logic mclk,
    input  wire logic rst_n,
    // control
    input  wire logic enable,
    input  wire logic rawIn,
    input  wire logic clrRise,
    input  wire logic clrFall,
    // status
    output logic      outState,
    output logic      riseFlag,
    output logic      fallFlag,
    output logic      riseEvt,
    output logic      fallEvt,
    output logic      settled
);
    import dcc_pkg::*;

    localparam logic [CNT_W-1:0] SETTLE_CNT = CNT_W'(SETTLE_CYCLES);

    logic             sync1_ff;
    logic             sync2_ff;
    logic             prev_ff;
    logic [CNT_W-1:0] cnt_ff;
    logic             riseFlag_ff;
    logic             fallFlag_ff;
    logic [CNT_W-1:0] nxt_cnt;
    logic             nxt_riseFlag;
    logic             nxt_fallFlag;
    logic             live;

    // ----------------------------------------
    // edge detect and flags
    // ----------------------------------------
    always_comb begin
        live         = enable && (cnt_ff == SETTLE_CNT);
        riseEvt      = live && sync2_ff && !prev_ff;
        fallEvt      = live && !sync2_ff && prev_ff;
        nxt_cnt      = cnt_ff;
        if (!enable) begin
            nxt_cnt = '0;
        end else if (cnt_ff != SETTLE_CNT) begin
            nxt_cnt = cnt_ff + CNT_W'(1);
        end
        // set wins over a software clear in the same cycle
        nxt_riseFlag = riseEvt || (riseFlag_ff && !clrRise);
        nxt_fallFlag = fallEvt || (fallFlag_ff && !clrFall);
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sync1_ff    <= 1'b0;
            sync2_ff    <= 1'b0;
            prev_ff     <= 1'b0;
            cnt_ff      <= '0;
            riseFlag_ff <= 1'b0;
            fallFlag_ff <= 1'b0;
        end else begin
            sync1_ff    <= rawIn;
            sync2_ff    <= sync1_ff;
            prev_ff     <= sync2_ff;
            cnt_ff      <= nxt_cnt;
            riseFlag_ff <= nxt_riseFlag;
            fallFlag_ff <= nxt_fallFlag;
        end
    end

    assign outState = sync2_ff;
    assign riseFlag = riseFlag_ff;
    assign fallFlag = fallFlag_ff;
    assign settled  = (cnt_ff == SETTLE_CNT);

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    property p_sync;
        riseEvt |-> $past(rawIn, 2) && !$past(rawIn, 3);
    endproperty
    a_sync: assert property (p_sync) else $error("rise edge not two stages behind input");

    property p_riseSet;
        riseEvt |=> riseFlag_ff;
    endproperty
    a_riseSet: assert property (p_riseSet) else $error("rise flag not set");

    property p_fallSet;
        fallEvt |=> fallFlag_ff;
    endproperty
    a_fallSet: assert property (p_fallSet) else $error("fall flag not set");

    property p_hold;
        (riseFlag_ff && !clrRise) or (fallFlag_ff && !clrFall) |=>
            ($past(riseFlag_ff && !clrRise) -> riseFlag_ff) &&
            ($past(fallFlag_ff && !clrFall) -> fallFlag_ff);
    endproperty
    a_hold: assert property (p_hold) else $error("event flag dropped by itself");

    property p_gate;
        !(enable && settled) |-> !riseEvt && !fallEvt;
    endproperty
    a_gate: assert property (p_gate) else $error("event while off or settling");

    property p_settle;
        $rose(enable) |-> !settled ##1 !settled;
    endproperty
    a_settle: assert property (p_settle) else $error("settled too early");

    property p_clear;
        clrRise && !riseEvt |=> !riseFlag_ff;
    endproperty
    a_clear: assert property (p_clear) else $error("rise flag not cleared");

endmodule

// >>> verilog/dcc_comparator_ctrl.sv
// top of the dual comparator control block with avalon-mm register slave
//
// Notes on behaviour
// - each enable bit powers its comparator independently
// - disabled comparator: pin low, no interrupts
// - interrupts on rising and falling output edges
// - rising edge sets the rise flag
// - falling edge sets the fall flag
// - flags stay set until software clears
// - output state readable at any time
// - hysteresis in control bits three to zero
// - positive bits 3-2, negative bits 1-0
// - output state one when plus exceeds minus
// - output edges and reset request ignored during power-on settle time
// - comparator zero may request system reset
// - comparator one identical, no reset source
// - outputs routable to pins, open-drain or push-pull
//
// Added by the designer: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "dcc_map.svh"
module dcc_comparator_ctrl #(
    parameter int SETTLE_CYCLES = (`DCC_CLK_HZ * `DCC_SETTLE_MS + `DCC_MS_PER_S - 1)
                                  / `DCC_MS_PER_S
) (
    // clock and reset
    input  wire logic                    mclk,
    input  wire logic                    rst_n,
    // avalon-mm slave
    input  wire logic [`DCC_ADDR_W-1:0]  address,
    input  wire logic                    read,
    input  wire logic                    write,
    input  wire logic [31:0]             writedata,
    input  wire logic [3:0]              byteenable,
    output logic      [31:0]             readdata,
    output logic                         waitrequest,
    // analog comparators
    input  wire logic [1:0]              cmpRaw,
    output dcc_pkg::dcc_ctrl_t           cmp0Ctl,
    output dcc_pkg::dcc_ctrl_t           cmp1Ctl,
    // port pins
    output dcc_pkg::dcc_pin_t            cmp0Pin,
    output dcc_pkg::dcc_pin_t            cmp1Pin,
    // system
    output logic                         irq,
    output logic                         cmpResetReq
);
    import dcc_pkg::*;

    // ----------------------------------------
    // state
    // ----------------------------------------
    dcc_ctrl_t                ctl0_ff;
    dcc_ctrl_t                ctl1_ff;
    logic [`DCC_CFG_W-1:0]    cfg_ff;
    logic [`DCC_IRQ_W-1:0]    irqStat_ff;
    logic [`DCC_IRQ_W-1:0]    irqMask_ff;
    logic                     waitReq_ff;
    logic [31:0]              readData_ff;
    logic                     irq_ff;
    dcc_pin_t                 pin0_ff;
    dcc_pin_t                 pin1_ff;
    logic                     rstReq_ff;

    dcc_ctrl_t                nxt_ctl0;
    dcc_ctrl_t                nxt_ctl1;
    logic [`DCC_CFG_W-1:0]    nxt_cfg;
    logic [`DCC_IRQ_W-1:0]    nxt_irqStat;
    logic [`DCC_IRQ_W-1:0]    nxt_irqMask;
    logic                     nxt_waitReq;
    logic [31:0]              nxt_readData;
    logic                     nxt_irq;
    dcc_pin_t                 nxt_pin0;
    dcc_pin_t                 nxt_pin1;
    logic                     nxt_rstReq;

    logic                     accept;
    logic                     wrLow;
    logic                     wrCtl0;
    logic                     wrCtl1;
    logic                     wrCfg;
    logic                     wrIstat;
    logic                     wrImask;
    logic [31:0]              rdMux;
    logic [`DCC_IRQ_W-1:0]    events;
    logic                     val0;
    logic                     val1;

    // channel status
    logic                     out0;
    logic                     out1;
    logic                     rise0;
    logic                     rise1;
    logic                     fall0;
    logic                     fall1;
    logic                     riseEvt0;
    logic                     riseEvt1;
    logic                     fallEvt0;
    logic                     fallEvt1;
    logic                     settled0;
    logic                     settled1;
    logic                     clrRise0;
    logic                     clrRise1;
    logic                     clrFall0;
    logic                     clrFall1;

    // ----------------------------------------
    // comparator channels
    // ----------------------------------------
    dcc_channel #(
        .SETTLE_CYCLES (SETTLE_CYCLES)
    ) u_ch0 (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .enable   (ctl0_ff.en),
        .rawIn    (cmpRaw[0]),
        .clrRise  (clrRise0),
        .clrFall  (clrFall0),
        .outState (out0),
        .riseFlag (rise0),
        .fallFlag (fall0),
        .riseEvt  (riseEvt0),
        .fallEvt  (fallEvt0),
        .settled  (settled0)
    );

    dcc_channel #(
        .SETTLE_CYCLES (SETTLE_CYCLES)
    ) u_ch1 (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .enable   (ctl1_ff.en),
        .rawIn    (cmpRaw[1]),
        .clrRise  (clrRise1),
        .clrFall  (clrFall1),
        .outState (out1),
        .riseFlag (rise1),
        .fallFlag (fall1),
        .riseEvt  (riseEvt1),
        .fallEvt  (fallEvt1),
        .settled  (settled1)
    );

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    always_comb begin
        accept   = (read || write) && !waitReq_ff;
        wrLow    = accept && write && byteenable[0];
        wrCtl0   = wrLow && (address == `DCC_OFS_CTL0);
        wrCtl1   = wrLow && (address == `DCC_OFS_CTL1);
        wrCfg    = wrLow && (address == `DCC_OFS_CFG);
        wrIstat  = wrLow && (address == `DCC_OFS_ISTAT);
        wrImask  = wrLow && (address == `DCC_OFS_IMASK);
        clrRise0 = wrCtl0 && !writedata[`DCC_BIT_RISE];
        clrFall0 = wrCtl0 && !writedata[`DCC_BIT_FALL];
        clrRise1 = wrCtl1 && !writedata[`DCC_BIT_RISE];
        clrFall1 = wrCtl1 && !writedata[`DCC_BIT_FALL];
        rdMux    = `DCC_RST_WORD;
        unique case (address)
            `DCC_OFS_CTL0: begin
                rdMux[`DCC_BIT_EN]            = ctl0_ff.en;
                rdMux[`DCC_BIT_OUT]           = out0;
                rdMux[`DCC_BIT_RISE]          = rise0;
                rdMux[`DCC_BIT_FALL]          = fall0;
                rdMux[`DCC_HYP_HI:`DCC_HYP_LO] = ctl0_ff.hystPos;
                rdMux[`DCC_HYN_HI:`DCC_HYN_LO] = ctl0_ff.hystNeg;
            end
            `DCC_OFS_CTL1: begin
                rdMux[`DCC_BIT_EN]            = ctl1_ff.en;
                rdMux[`DCC_BIT_OUT]           = out1;
                rdMux[`DCC_BIT_RISE]          = rise1;
                rdMux[`DCC_BIT_FALL]          = fall1;
                rdMux[`DCC_HYP_HI:`DCC_HYP_LO] = ctl1_ff.hystPos;
                rdMux[`DCC_HYN_HI:`DCC_HYN_LO] = ctl1_ff.hystNeg;
            end
            `DCC_OFS_CFG:    rdMux[`DCC_CFG_W-1:0] = cfg_ff;
            `DCC_OFS_ISTAT:  rdMux[`DCC_IRQ_W-1:0] = irqStat_ff;
            `DCC_OFS_IMASK:  rdMux[`DCC_IRQ_W-1:0] = irqMask_ff;
            `DCC_OFS_SETTLE: begin
                rdMux[`DCC_SET_CMP0] = settled0;
                rdMux[`DCC_SET_CMP1] = settled1;
            end
            default:         rdMux = `DCC_RST_WORD;
        endcase
    end

    // ----------------------------------------
    // register next values
    // ----------------------------------------
    always_comb begin
        // one wait cycle, then a one-cycle answer
        nxt_waitReq  = !((read || write) && waitReq_ff);
        nxt_readData = (read && waitReq_ff) ? rdMux : readData_ff;
        nxt_ctl0     = ctl0_ff;
        nxt_ctl1     = ctl1_ff;
        nxt_cfg      = wrCfg ? writedata[`DCC_CFG_W-1:0] : cfg_ff;
        nxt_irqMask  = wrImask ? writedata[`DCC_IRQ_W-1:0] : irqMask_ff;
        if (wrCtl0) begin
            nxt_ctl0.en      = writedata[`DCC_BIT_EN];
            nxt_ctl0.hystPos = writedata[`DCC_HYP_HI:`DCC_HYP_LO];
            nxt_ctl0.hystNeg = writedata[`DCC_HYN_HI:`DCC_HYN_LO];
        end
        if (wrCtl1) begin
            nxt_ctl1.en      = writedata[`DCC_BIT_EN];
            nxt_ctl1.hystPos = writedata[`DCC_HYP_HI:`DCC_HYP_LO];
            nxt_ctl1.hystNeg = writedata[`DCC_HYN_HI:`DCC_HYN_LO];
        end
        events                 = '0;
        events[`DCC_IRQ_RISE0] = riseEvt0;
        events[`DCC_IRQ_FALL0] = fallEvt0;
        events[`DCC_IRQ_RISE1] = riseEvt1;
        events[`DCC_IRQ_FALL1] = fallEvt1;
        // write one clears; a new event in the same cycle wins
        nxt_irqStat = (irqStat_ff & ~(wrIstat ? writedata[`DCC_IRQ_W-1:0] : `DCC_RST_IRQ))
                      | events;
        nxt_irq     = |(irqStat_ff & irqMask_ff);
        // disabled comparator drives a low level
        val0        = ctl0_ff.en && out0;
        val1        = ctl1_ff.en && out1;
        nxt_pin0.out = cfg_ff[`DCC_CFG_PP0] ? val0 : 1'b0;
        nxt_pin0.oe  = cfg_ff[`DCC_CFG_ROUTE0] && (cfg_ff[`DCC_CFG_PP0] || !val0);
        nxt_pin1.out = cfg_ff[`DCC_CFG_PP1] ? val1 : 1'b0;
        nxt_pin1.oe  = cfg_ff[`DCC_CFG_ROUTE1] && (cfg_ff[`DCC_CFG_PP1] || !val1);
        // only comparator zero feeds the reset logic
        nxt_rstReq  = cfg_ff[`DCC_CFG_RST0] && ctl0_ff.en && settled0 && !out0;
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ctl0_ff     <= '{en: 1'b0, hystPos: `DCC_HYST_OFF, hystNeg: `DCC_HYST_OFF};
            ctl1_ff     <= '{en: 1'b0, hystPos: `DCC_HYST_OFF, hystNeg: `DCC_HYST_OFF};
            cfg_ff      <= `DCC_RST_CFG;
            irqStat_ff  <= `DCC_RST_IRQ;
            irqMask_ff  <= `DCC_RST_IRQ;
            waitReq_ff  <= 1'b1;
            readData_ff <= `DCC_RST_WORD;
            irq_ff      <= 1'b0;
            pin0_ff     <= '{out: 1'b0, oe: 1'b0};
            pin1_ff     <= '{out: 1'b0, oe: 1'b0};
            rstReq_ff   <= 1'b0;
        end else begin
            ctl0_ff     <= nxt_ctl0;
            ctl1_ff     <= nxt_ctl1;
            cfg_ff      <= nxt_cfg;
            irqStat_ff  <= nxt_irqStat;
            irqMask_ff  <= nxt_irqMask;
            waitReq_ff  <= nxt_waitReq;
            readData_ff <= nxt_readData;
            irq_ff      <= nxt_irq;
            pin0_ff     <= nxt_pin0;
            pin1_ff     <= nxt_pin1;
            rstReq_ff   <= nxt_rstReq;
        end
    end

    assign readdata    = readData_ff;
    assign waitrequest = waitReq_ff;
    assign cmp0Ctl     = ctl0_ff;
    assign cmp1Ctl     = ctl1_ff;
    assign cmp0Pin     = pin0_ff;
    assign cmp1Pin     = pin1_ff;
    assign irq         = irq_ff;
    assign cmpResetReq = rstReq_ff;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    property p_enable;
        wrCtl0 |=> cmp0Ctl.en == $past(writedata[`DCC_BIT_EN]) && cmp1Ctl.en == $past(ctl1_ff.en);
    endproperty
    a_enable: assert property (p_enable) else $error("enable write wrong");

    property p_enable1;
        wrCtl1 |=> cmp1Ctl.en == $past(writedata[`DCC_BIT_EN]) && cmp0Ctl.en == $past(ctl0_ff.en);
    endproperty
    a_enable1: assert property (p_enable1) else $error("enable write wrong on second");

    property p_pinLow;
        !ctl0_ff.en |=> !cmp0Pin.out;
    endproperty
    a_pinLow: assert property (p_pinLow) else $error("pin high while disabled");

    property p_irq;
        (riseEvt0 && irqMask_ff[`DCC_IRQ_RISE0]) ##1 irqMask_ff[`DCC_IRQ_RISE0] |=> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("unmasked edge gave no interrupt");

    property p_state;
        read && waitReq_ff && (address == `DCC_OFS_CTL0) |=>
            readdata[`DCC_BIT_OUT] == $past(out0) && !waitrequest;
    endproperty
    a_state: assert property (p_state) else $error("output state read wrong");

    property p_hyst;
        wrCtl0 |=> cmp0Ctl.hystPos == $past(writedata[`DCC_HYP_HI:`DCC_HYP_LO])
                && cmp0Ctl.hystNeg == $past(writedata[`DCC_HYN_HI:`DCC_HYN_LO]);
    endproperty
    a_hyst: assert property (p_hyst) else $error("hysteresis fields wrong");

    property p_rst;
        cmpResetReq |-> $past(cfg_ff[`DCC_CFG_RST0]) && $past(ctl0_ff.en) && !$past(out0);
    endproperty
    a_rst: assert property (p_rst) else $error("reset request without cause");

    property p_pushPull;
        cfg_ff[`DCC_CFG_ROUTE0] && cfg_ff[`DCC_CFG_PP0] |=> cmp0Pin.oe;
    endproperty
    a_pushPull: assert property (p_pushPull) else $error("push-pull pin not driven");

    property p_wait;
        (read || write) && waitrequest |=> !waitrequest ##1 waitrequest;
    endproperty
    a_wait: assert property (p_wait) else $error("bus answer timing wrong");

endmodule

// >>> verif/dcc_cmp_model.sv
// behavioural analog comparator with selectable hysteresis
`timescale 1ns/1ps
module dcc_cmp_model (
    // clock
    input  wire logic          mclk,
    // analog side in millivolts
    input  int                 vPlus,
    input  int                 vMinus,
    input  dcc_pkg::dcc_ctrl_t ctl,
    // raw output
    output logic               raw
);
    import dcc_pkg::*;
    function automatic int hyst(logic [1:0] c);
        case (c)
            2'h1: return 2;
            2'h2: return 4;
            2'h3: return 10;
            default: return 0;
        endcase
    endfunction
    initial raw = 1'b0;
    // powered down output is meaningless: let it wander
    always @(posedge mclk) begin
        if (!ctl.en) begin
            raw <= ~raw;
        end else if (!raw && vPlus > vMinus + hyst(ctl.hystPos)) begin
            raw <= 1'b1;
        end else if (raw && vPlus < vMinus - hyst(ctl.hystNeg)) begin
            raw <= 1'b0;
        end
    end
endmodule

// >>> verif/dcc_comparator_ctrl_tb_top.sv
// testbench of the dual comparator control block
`timescale 1ns/1ps
`include "dcc_map.svh"
module dcc_comparator_ctrl_tb_top;
    import dcc_pkg::*;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic [5:0]  address = 6'h00;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic        waitrequest;
    logic [1:0]  cmpRaw;
    dcc_ctrl_t   cmp0Ctl;
    dcc_ctrl_t   cmp1Ctl;
    dcc_pin_t    cmp0Pin;
    dcc_pin_t    cmp1Pin;
    logic        irq;
    logic        cmpResetReq;
    logic [31:0] rdv;
    int          vP0 = 900;
    int          vP1 = 900;
    int          failures = 0;
    int          tests_run = 0;

    always #10 mclk = ~mclk;

    dcc_comparator_ctrl #(.SETTLE_CYCLES(16)) DUT (.mclk(mclk), .rst_n(rst_n),
        .address(address), .read(read), .write(write), .writedata(writedata),
        .byteenable(4'hf), .readdata(readdata), .waitrequest(waitrequest),
        .cmpRaw(cmpRaw), .cmp0Ctl(cmp0Ctl), .cmp1Ctl(cmp1Ctl), .cmp0Pin(cmp0Pin),
        .cmp1Pin(cmp1Pin), .irq(irq), .cmpResetReq(cmpResetReq));
    dcc_cmp_model cmpA (.mclk(mclk), .vPlus(vP0), .vMinus(1000), .ctl(cmp0Ctl), .raw(cmpRaw[0]));
    dcc_cmp_model cmpB (.mclk(mclk), .vPlus(vP1), .vMinus(1000), .ctl(cmp1Ctl), .raw(cmpRaw[1]));

    task automatic print_verdict;
        $display("tests_run=%0d failures=%0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask

    // one avalon transfer, held until waitrequest is sampled low
    task automatic bus(logic wr, logic [5:0] a, logic [31:0] d);
        int n;
        @(posedge mclk);
        address <= a;
        writedata <= d;
        read <= !wr;
        write <= wr;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (waitrequest !== 1'b0 && n < 20);
        rdv = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (waitrequest !== 1'b0) begin
            failures++;
            print_verdict();
        end
    endtask

    task automatic rdc(string name, logic [5:0] a, logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        check(name, rdv, exp);
    endtask

    task automatic tick(int n);
        repeat (n) @(posedge mclk);
    endtask

    task automatic wait_set(int b);
        for (int n = 0; n < 40; n++) begin
            bus(1'b0, `DCC_OFS_SETTLE, 32'h0);
            if (rdv[b] === 1'b1) return;
        end
        failures++;
        print_verdict();
    endtask

    task automatic t_reset;
        logic [5:0] ofs [7] = '{6'h00, 6'h04, 6'h08, 6'h0c, 6'h10, 6'h14, 6'h3c};
        bus(1'b1, 6'h3c, 32'h0000_00ff);
        foreach (ofs[i]) begin
            bus(1'b0, ofs[i], 32'h0);
            // output state of a disabled comparator follows its wandering input
            if (ofs[i] < `DCC_OFS_CFG) rdv[`DCC_BIT_OUT] = 1'b0;
            check("reset value", rdv, 32'h0);
        end
        check("irq", irq, 32'h0);
    endtask

    task automatic t_hyst;
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, `DCC_OFS_CTL0, 32'h80 | (i << 2) | (3 - i));
            tick(2);
            check("ctl0", cmp0Ctl, {1'b1, 2'(i), 2'(3 - i)});
            check("ctl1", cmp1Ctl, 32'h0);
        end
        bus(1'b1, `DCC_OFS_CTL0, 32'h0d);
    endtask

    task automatic t_evt;
        bus(1'b1, `DCC_OFS_IMASK, 32'h1);
        vP0 <= 1020;
        bus(1'b1, `DCC_OFS_CTL0, 32'h8d);
        rdc("settle", `DCC_OFS_SETTLE, 32'h0);
        wait_set(0);
        rdc("ctl0", `DCC_OFS_CTL0, 32'hcd);
        vP0 <= 900;
        tick(6);
        rdc("ctl0", `DCC_OFS_CTL0, 32'h9d);
        rdc("istat", `DCC_OFS_ISTAT, 32'h2);
        check("irq", irq, 32'h0);
        vP0 <= 1020;
        tick(6);
        rdc("ctl0", `DCC_OFS_CTL0, 32'hfd);
        check("irq", irq, 32'h1);
        bus(1'b1, `DCC_OFS_CTL0, 32'hbd);
        rdc("ctl0", `DCC_OFS_CTL0, 32'hfd);
        bus(1'b1, `DCC_OFS_CTL0, 32'h8d);
        rdc("ctl0", `DCC_OFS_CTL0, 32'hcd);
        bus(1'b1, `DCC_OFS_ISTAT, 32'h1);
        rdc("istat", `DCC_OFS_ISTAT, 32'h2);
        tick(3);
        check("irq", irq, 32'h0);
        bus(1'b1, `DCC_OFS_IMASK, 32'h2);
        tick(3);
        check("irq", irq, 32'h1);
        bus(1'b1, `DCC_OFS_ISTAT, 32'h2);
        tick(3);
        check("irq", irq, 32'h0);
    endtask

    task automatic t_pin;
        bus(1'b1, `DCC_OFS_CFG, 32'h0a);
        tick(3);
        check("pin0", cmp0Pin, 32'h3);
        bus(1'b1, `DCC_OFS_CFG, 32'h02);
        tick(3);
        check("pin0", cmp0Pin, 32'h0);
        check("rstreq", cmpResetReq, 32'h0);
        vP0 <= 900;
        tick(6);
        check("pin0", cmp0Pin, 32'h1);
        bus(1'b1, `DCC_OFS_CFG, 32'h01);
        tick(3);
        check("rstreq", cmpResetReq, 32'h1);
    endtask

    task automatic t_dis;
        bus(1'b1, `DCC_OFS_CTL0, 32'h0d);
        bus(1'b1, `DCC_OFS_CFG, 32'h0b);
        bus(1'b1, `DCC_OFS_ISTAT, 32'hf);
        tick(20);
        bus(1'b0, `DCC_OFS_CTL0, 32'h0);
        check("ctl0", rdv & 32'hbf, 32'h0d);
        rdc("istat", `DCC_OFS_ISTAT, 32'h0);
        check("pin0", cmp0Pin, 32'h1);
        check("rstreq", cmpResetReq, 32'h0);
    endtask

    task automatic t_cmp1;
        bus(1'b1, `DCC_OFS_CFG, 32'h05);
        bus(1'b1, `DCC_OFS_CTL1, 32'h82);
        tick(2);
        check("ctl1", cmp1Ctl, 32'h12);
        wait_set(1);
        vP1 <= 1020;
        tick(6);
        rdc("ctl1", `DCC_OFS_CTL1, 32'he2);
        rdc("istat", `DCC_OFS_ISTAT, 32'h4);
        vP1 <= 900;
        tick(6);
        rdc("istat", `DCC_OFS_ISTAT, 32'hc);
        check("pin1", cmp1Pin, 32'h1);
        check("rstreq", cmpResetReq, 32'h0);
    endtask

    initial begin
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        t_reset();
        t_hyst();
        t_evt();
        t_pin();
        t_dis();
        t_cmp1();
        print_verdict();
    end
endmodule
